// *** logic/channel_setup_diag_regs.v ***
// Channel, setup and diagnostic register bank with serial port and channel sequencer
`timescale 1ns/1ps
`default_nettype none
`include "chan_setup_defs.vh"

module channel_setup_diag_regs #(
  parameter [7:0]  ID_VALUE     = 8'h3C,          // Arbitrary identity value
  parameter [23:0] GAIN_DEFAULT = 24'h555555,     // Per-part trim stands in here
  parameter        CONV_CYCLES  = `CONV_CYCLES,
  parameter        IGNORE_CYC   = `IGNORE_CYCLES
) (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        din,
  input  wire        cal_zero_done,
  input  wire        cal_full_done,
  input  wire [23:0] cal_result,
  output reg         dout,
  output reg         dout_oe_n,
  output reg         conv_start,
  output reg  [3:0]  active_channel,
  output reg  [4:0]  pos_select,
  output reg  [4:0]  neg_select,
  output reg  [15:0] conv_config,
  output reg  [23:0] conv_filter,
  output reg  [23:0] conv_offset,
  output reg  [23:0] conv_gain,
  output reg         err_summary
);

  localparam [1:0] SEQ_IDLE = 2'b01;
  localparam [1:0] SEQ_CONV = 2'b10;

  // Register bases as sized constants so their low bits can be sliced for indexing
  localparam [5:0]  CHAN_BASE   = `REG_CHAN_BASE;
  localparam [5:0]  CFG_BASE    = `REG_CFG_BASE;
  localparam [5:0]  FILT_BASE   = `REG_FILT_BASE;
  localparam [5:0]  OFFS_BASE   = `REG_OFFS_BASE;
  localparam [5:0]  GAIN_BASE   = `REG_GAIN_BASE;
  localparam [31:0] MCLK_DIV_M1 = `MCLK_DIV - 1;

  // Synchronisers; stage one feeds only stage two
  reg        sclk_s1_r, sclk_s2_r, sclk_s3_r;
  reg        cs_s1_r, cs_s2_r, cs_s3_r;
  reg        din_s1_r, din_s2_r;

  reg [15:0] chan_r  [0:15];
  reg [15:0] cfg_r   [0:7];
  reg [23:0] filt_r  [0:7];
  reg [23:0] offs_r  [0:7];
  reg [23:0] gain_r  [0:7];
  reg [15:0] ctrl_r;
  reg [23:0] err_en_r;
  reg [23:0] err_r;
  reg [7:0]  mclk_cnt_r;
  reg [7:0]  mclk_div_r;
  reg [15:0] ignore_cnt_r;

  reg        data_phase_r;
  reg [4:0]  bit_cnt_r;
  reg [6:0]  cmd_sh_r;
  reg [5:0]  addr_r;
  reg        is_read_r;
  reg        wr_block_r;
  reg [4:0]  width_r;
  reg [22:0] in_sh_r;
  reg [23:0] out_sh_r;

  reg [1:0]  seq_state_r;
  reg [31:0] conv_cnt_r;

  wire sclk_rise = sclk_s2_r & ~sclk_s3_r & ~cs_s2_r;
  wire sclk_fall = ~sclk_s2_r & sclk_s3_r & ~cs_s2_r;
  wire cs_rise   = cs_s2_r & ~cs_s3_r;
  wire ignore_on = (ignore_cnt_r != 16'h0000);
  wire mclk_tick = (mclk_div_r == 8'h00);

  wire [7:0] cmd_byte = {cmd_sh_r, din_s2_r};
  wire [5:0] cmd_addr = cmd_byte[5:0];
  wire       cmd_rd   = cmd_byte[`CMD_RW_BIT];

  // Access width per address; zero marks an address with no register
  function [4:0] reg_width;
    input [5:0] a;
    begin
      if (a == `REG_STATUS || a == `REG_ID || a == `REG_MCLK_CNT)
        reg_width = 5'd8;
      else if (a == `REG_CONTROL || (a >= `REG_CHAN_BASE && a < `REG_FILT_BASE - 6'h07))
        reg_width = 5'd16;
      else if (a == `REG_ERROR || a == `REG_ERR_EN ||
               (a >= `REG_FILT_BASE - 6'h07 && a <= `REG_LAST))
        reg_width = 5'd24;
      else
        reg_width = 5'd0;
    end
  endfunction

  function is_read_only;
    input [5:0] a;
    begin
      is_read_only = (a == `REG_STATUS) || (a == `REG_ID) ||
                     (a == `REG_ERROR) || (a == `REG_MCLK_CNT);
    end
  endfunction

  // Next enabled channel in ascending order with wrap; bit 4 says one was found
  function [4:0] next_enabled;
    input [3:0]  cur;
    input [15:0] en;
    input        incl;
    integer      k;
    reg   [3:0]  base;
    reg   [3:0]  idx;
    begin
      next_enabled = 5'h00;
      base = incl ? cur : cur + 4'h1;
      for (k = 15; k >= 0; k = k - 1)
      begin
        idx = base + k[3:0];
        if (en[idx])
          next_enabled = {1'b1, idx};
      end
    end
  endfunction

  wire [4:0] cmd_width = reg_width(cmd_addr);

  // Read word, left aligned so the shifter always starts from bit 23
  reg [23:0] rd_word;
  reg [2:0]  rd_idx3;
  always @*
  begin
    rd_word = 24'h000000;
    rd_idx3 = 3'h0;
    if (cmd_addr == `REG_STATUS)
      rd_word = {seq_state_r[1], err_summary, 2'b00, active_channel, 16'h0000};
    else if (cmd_addr == `REG_CONTROL)
      rd_word = {ctrl_r, 8'h00};
    else if (cmd_addr == `REG_ID)
      rd_word = {ID_VALUE, 16'h0000};
    else if (cmd_addr == `REG_ERROR)
      rd_word = err_r;
    else if (cmd_addr == `REG_ERR_EN)
      rd_word = err_en_r;
    else if (cmd_addr == `REG_MCLK_CNT)
      rd_word = {mclk_cnt_r, 16'h0000};
    else if (cmd_addr >= `REG_CHAN_BASE && cmd_addr < `REG_CFG_BASE)
      rd_word = {chan_r[cmd_addr[3:0] - CHAN_BASE[3:0]], 8'h00};
    else if (cmd_addr >= `REG_CFG_BASE && cmd_addr < `REG_FILT_BASE - 6'h07)
    begin
      rd_idx3 = cmd_addr[2:0] - CFG_BASE[2:0];
      rd_word = {cfg_r[rd_idx3], 8'h00};
    end
    else if (cmd_addr >= `REG_FILT_BASE - 6'h07 && cmd_addr <= `REG_FILT_BASE)
    begin
      rd_idx3 = FILT_BASE[2:0] - cmd_addr[2:0];
      rd_word = filt_r[rd_idx3];
    end
    else if (cmd_addr >= `REG_OFFS_BASE && cmd_addr < `REG_GAIN_BASE)
    begin
      rd_idx3 = cmd_addr[2:0] - OFFS_BASE[2:0];
      rd_word = offs_r[rd_idx3];
    end
    else if (cmd_addr >= `REG_GAIN_BASE && cmd_addr <= `REG_LAST)
    begin
      rd_idx3 = cmd_addr[2:0] - GAIN_BASE[2:0];
      rd_word = gain_r[rd_idx3];
    end
  end

  // Command and data decode on the serial clock sample edge
  wire cmd_done  = sclk_rise & ~data_phase_r & (bit_cnt_r == 5'd7);
  wire cmd_ok    = cmd_done & ~cmd_byte[`CMD_WEN_BIT] & (cmd_width != 5'd0);
  wire cmd_bad   = cmd_done & ~cmd_byte[`CMD_WEN_BIT] &
                   ((cmd_width == 5'd0) | (~cmd_rd & is_read_only(cmd_addr)));
  wire data_done = sclk_rise & data_phase_r & (bit_cnt_r == width_r - 5'd1);
  wire wr_fire   = data_done & ~is_read_r & ~wr_block_r;
  wire [23:0] wr_data = {in_sh_r, din_s2_r};
  wire err_clr   = data_done & is_read_r & (addr_r == `REG_ERROR);

  wire [23:0] evt_mask = ({23'h0, cmd_ok & ~cmd_rd & ignore_on} << `ERR_IGNORE_BIT) |
                         ({23'h0, cmd_bad & cmd_rd} << `ERR_READ_BIT) |
                         ({23'h0, cmd_bad & ~cmd_rd} << `ERR_WRITE_BIT) |
                         ({23'h0, cs_rise & (data_phase_r | (bit_cnt_r != 5'd0))}
                           << `ERR_SCLK_BIT);

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclk_s1_r <= 1'b1;
      sclk_s2_r <= 1'b1;
      sclk_s3_r <= 1'b1;
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      cs_s3_r   <= 1'b1;
      din_s1_r  <= 1'b1;
      din_s2_r  <= 1'b1;
    end
    else
    begin
      sclk_s1_r <= sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      cs_s1_r   <= cs_n;
      cs_s2_r   <= cs_s1_r;
      cs_s3_r   <= cs_s2_r;
      din_s1_r  <= din;
      din_s2_r  <= din_s1_r;
    end
  end

  // Serial engine: command byte, then data of the addressed width
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      data_phase_r <= 1'b0;
      bit_cnt_r    <= 5'd0;
      cmd_sh_r     <= 7'h00;
      addr_r       <= 6'h00;
      is_read_r    <= 1'b0;
      wr_block_r   <= 1'b0;
      width_r      <= 5'd0;
      in_sh_r      <= 23'h000000;
      out_sh_r     <= 24'hFFFFFF;
      dout         <= 1'b1;
      dout_oe_n    <= 1'b1;
    end
    else
    begin
      dout_oe_n <= cs_s2_r;
      if (cs_s2_r)
      begin
        // Deselect aborts any partial access
        data_phase_r <= 1'b0;
        bit_cnt_r    <= 5'd0;
        dout         <= 1'b1;
      end
      else if (sclk_rise & ~data_phase_r)
      begin
        cmd_sh_r  <= cmd_byte[6:0];
        bit_cnt_r <= (bit_cnt_r == 5'd7) ? 5'd0 : bit_cnt_r + 5'd1;
        if (cmd_ok & ~(~cmd_rd & is_read_only(cmd_addr)))
        begin
          data_phase_r <= 1'b1;
          addr_r       <= cmd_addr;
          is_read_r    <= cmd_rd;
          wr_block_r   <= ignore_on;
          width_r      <= cmd_width;
          out_sh_r     <= rd_word;
        end
      end
      else if (sclk_rise)
      begin
        in_sh_r   <= wr_data[22:0];
        bit_cnt_r <= bit_cnt_r + 5'd1;
        if (data_done)
        begin
          data_phase_r <= 1'b0;
          bit_cnt_r    <= 5'd0;
        end
      end
      else if (sclk_fall & data_phase_r & is_read_r)
      begin
        dout     <= out_sh_r[23];
        out_sh_r <= {out_sh_r[22:0], 1'b1};
      end
    end
  end

  // Register storage, host writes, calibration updates and diagnostics
  integer      i;
  wire [2:0]   wr_cfg_idx  = addr_r[2:0] - CFG_BASE[2:0];
  wire [2:0]   wr_filt_idx = FILT_BASE[2:0] - addr_r[2:0];
  wire [2:0]   wr_offs_idx = addr_r[2:0] - OFFS_BASE[2:0];
  wire [2:0]   wr_gain_idx = addr_r[2:0] - GAIN_BASE[2:0];
  wire [2:0]   act_setup   = chan_r[active_channel][`CH_SETUP_MSB:`CH_SETUP_LSB];

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (i = 0; i < 16; i = i + 1)
        chan_r[i] <= (i == 0) ? `CHAN0_RST : `CHANX_RST;
      for (i = 0; i < 8; i = i + 1)
      begin
        cfg_r[i]  <= `CFG_RST;
        filt_r[i] <= `FILT_RST;
        offs_r[i] <= `OFFS_RST;
        gain_r[i] <= GAIN_DEFAULT;
      end
      ctrl_r       <= `CTRL_RST;
      err_en_r     <= `ERR_EN_RST;
      err_r        <= 24'h000000;
      mclk_cnt_r   <= 8'h00;
      mclk_div_r   <= 8'h00;
      ignore_cnt_r <= IGNORE_CYC[15:0];
      err_summary  <= 1'b0;
    end
    else
    begin
      if (ignore_on)
        ignore_cnt_r <= ignore_cnt_r - 16'h0001;
      mclk_div_r <= mclk_tick ? MCLK_DIV_M1[7:0] : mclk_div_r - 8'd1;
      if (mclk_tick & err_en_r[`EN_MCLK_CNT_BIT])
        mclk_cnt_r <= mclk_cnt_r + 8'h01;
      // Set wins over the read clear; disabled checks hold zero
      err_r <= ((err_r & ~{24{err_clr}}) | evt_mask) & err_en_r;
      err_summary <= |(err_r & err_en_r);
      if (cal_zero_done)
        offs_r[act_setup] <= cal_result;
      if (cal_full_done)
        gain_r[act_setup] <= cal_result;
      // Host write is the later event and takes the register on a tie
      if (wr_fire)
      begin
        if (addr_r == `REG_CONTROL)
          ctrl_r <= wr_data[15:0];
        else if (addr_r == `REG_ERR_EN)
          err_en_r <= wr_data;
        else if (addr_r >= `REG_CHAN_BASE && addr_r < `REG_CFG_BASE)
          chan_r[addr_r[3:0] - CHAN_BASE[3:0]] <= wr_data[15:0];
        else if (addr_r >= `REG_CFG_BASE && addr_r < `REG_FILT_BASE - 6'h07)
          cfg_r[wr_cfg_idx] <= wr_data[15:0];
        else if (addr_r >= `REG_FILT_BASE - 6'h07 && addr_r <= `REG_FILT_BASE)
          filt_r[wr_filt_idx] <= wr_data;
        else if (addr_r >= `REG_OFFS_BASE && addr_r < `REG_GAIN_BASE)
          offs_r[wr_offs_idx] <= wr_data;
        else if (addr_r >= `REG_GAIN_BASE && addr_r <= `REG_LAST)
          gain_r[wr_gain_idx] <= wr_data;
      end
    end
  end

  // Channel sequencer; the converter is modelled by a fixed conversion time
  wire [15:0] chan_en;
  genvar      g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_chan_en
      assign chan_en[g] = chan_r[g][`CH_EN_BIT];
    end
  endgenerate

  wire       run_cont  = (ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_CONT);
  wire [4:0] first_ch  = next_enabled(4'h0, chan_en, 1'b1);
  wire [4:0] follow_ch = next_enabled(active_channel, chan_en, 1'b0);

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      seq_state_r    <= SEQ_IDLE;
      conv_cnt_r     <= 32'd0;
      conv_start     <= 1'b0;
      active_channel <= 4'h0;
      pos_select     <= 5'h00;
      neg_select     <= 5'h00;
      conv_config    <= 16'h0000;
      conv_filter    <= 24'h000000;
      conv_offset    <= 24'h000000;
      conv_gain      <= 24'h000000;
    end
    else
    begin
      conv_start <= 1'b0;
      case (seq_state_r)
        SEQ_IDLE:
        begin
          if (run_cont & first_ch[4])
          begin
            active_channel <= first_ch[3:0];
            seq_state_r    <= SEQ_CONV;
            conv_start     <= 1'b1;
            conv_cnt_r     <= 32'd0;
          end
        end
        SEQ_CONV:
        begin
          if (conv_cnt_r == CONV_CYCLES - 1)
          begin
            conv_cnt_r <= 32'd0;
            if (run_cont & follow_ch[4])
            begin
              active_channel <= follow_ch[3:0];
              conv_start     <= 1'b1;
            end
            else
              seq_state_r <= SEQ_IDLE;
          end
          else
            conv_cnt_r <= conv_cnt_r + 32'd1;
        end
        default:
          seq_state_r <= SEQ_IDLE;
      endcase
      // Setup of the converting channel drives the converter; bit 11 sets coding
      pos_select  <= chan_r[active_channel][`CH_POS_MSB:`CH_POS_LSB];
      neg_select  <= chan_r[active_channel][`CH_NEG_MSB:`CH_NEG_LSB];
      conv_config <= cfg_r[act_setup];
      conv_filter <= filt_r[act_setup];
      conv_offset <= offs_r[act_setup];
      conv_gain   <= gain_r[act_setup];
    end
  end

endmodule // channel_setup_diag_regs
`default_nettype wire

// *** logic/chan_setup_defs.vh ***
// Register offsets, field positions, reset values and timing counts
`ifndef CHAN_SETUP_DEFS_VH
`define CHAN_SETUP_DEFS_VH

`define REG_STATUS      6'h00
`define REG_CONTROL     6'h01
`define REG_ID          6'h05
`define REG_ERROR       6'h06
`define REG_ERR_EN      6'h07
`define REG_MCLK_CNT    6'h08
`define REG_CHAN_BASE   6'h09
`define REG_CFG_BASE    6'h19
`define REG_FILT_BASE   6'h28
`define REG_OFFS_BASE   6'h29
`define REG_GAIN_BASE   6'h31
`define REG_LAST        6'h38

`define CHAN0_RST       16'h8001
`define CHANX_RST       16'h0001
`define CFG_RST         16'h0000
`define FILT_RST        24'h060180
`define OFFS_RST        24'h800000
`define CTRL_RST        16'h0000
`define ERR_EN_RST      24'h000040

`define CMD_WEN_BIT     7
`define CMD_RW_BIT      6
`define CH_EN_BIT       15
`define CH_SETUP_MSB    14
`define CH_SETUP_LSB    12
`define CH_POS_MSB      9
`define CH_POS_LSB      5
`define CH_NEG_MSB      4
`define CH_NEG_LSB      0
`define CFG_BIPOLAR_BIT 11
`define CFG_REFSEL_MSB  4
`define CFG_REFSEL_LSB  3
`define CTRL_MODE_MSB   5
`define CTRL_MODE_LSB   2
`define MODE_CONT       4'h0

`define ERR_IGNORE_BIT  6
`define ERR_SCLK_BIT    5
`define ERR_READ_BIT    4
`define ERR_WRITE_BIT   3
`define EN_MCLK_CNT_BIT 22

`define CORE_HZ         100000000
`define MCLK_HZ         614400
`define MCLK_DIV        (`CORE_HZ / `MCLK_HZ)
`define CORE_PERIOD_NS  10
`define IGNORE_TIME_NS  2000
`define IGNORE_CYCLES   ((`IGNORE_TIME_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define CONV_TIME_NS    20000
`define CONV_CYCLES     (`CONV_TIME_NS / `CORE_PERIOD_NS)

`endif

// *** verification/channel_setup_diag_regs_sva.sv ***
// Port-level checker for the channel, setup and diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module channel_setup_diag_regs_sva #(
  parameter CONV_CYCLES = 20
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        cs_n,
  input wire logic        cal_zero_done,
  input wire logic        cal_full_done,
  input wire logic [23:0] cal_result,
  input wire logic        dout,
  input wire logic        dout_oe_n,
  input wire logic        conv_start,
  input wire logic [3:0]  active_channel,
  input wire logic [23:0] conv_offset,
  input wire logic [23:0] conv_gain
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Cycles since the last start; saturates so an idle restart never trips the gap check
  logic [15:0] gap_r;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      gap_r <= 16'hFFFF;
    else if (conv_start)
      gap_r <= 16'h0000;
    else if (gap_r != 16'hFFFF)
      gap_r <= gap_r + 16'h0001;
  end

  a_conv_spacing: assert property (conv_start |-> gap_r >= CONV_CYCLES - 1)
    else $error("conversion started before the previous one ended");
  a_chan_change: assert property ($changed(active_channel) |-> conv_start)
    else $error("active channel moved without a conversion start");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_offset_cal: assert property (cal_zero_done ##1 !conv_start ##1 !conv_start
    |-> conv_offset == $past(cal_result, 2))
    else $error("zero-scale result not applied to active offset");
  a_gain_cal: assert property (cal_full_done ##1 !conv_start ##1 !conv_start
    |-> conv_gain == $past(cal_result, 2))
    else $error("full-scale result not applied to active gain");
  a_oe_idle: assert property (cs_n [*4] |-> dout_oe_n)
    else $error("data out driven while deselected");
  a_oe_active: assert property (!cs_n [*4] |-> !dout_oe_n)
    else $error("data out not driven while selected");
  a_dout_idle: assert property (dout_oe_n && $past(dout_oe_n) |-> dout)
    else $error("data out not high while released");
endmodule // channel_setup_diag_regs_sva
`default_nettype wire

// *** verification/host_port_model.sv ***
// Host side of the serial port: mode 3 master, clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b1;
  end

  // Command byte then n data bits, MSB first; n short of the width cuts the access
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] wd,
                      output logic [23:0] rd);
    logic [31:0] sh;
    int          i;
    rd   = 24'h000000;
    sh   = {cmd, wd << (24 - n)};
    cs_n = 1'b0;
    #80;
    for (i = 0; i < 8 + n; i++)
    begin
      sclk = 1'b0;
      din  = sh[31];
      sh   = sh << 1;
      #80;
      sclk = 1'b1;
      if (i >= 8)
        rd = {rd[22:0], dout};
      #80;
    end
    cs_n = 1'b1;
    // Released line must not keep showing the last bit
    din  = ~din;
    #320;
  endtask
endmodule // host_port_model
`default_nettype wire

// *** verification/channel_setup_diag_regs_bench.sv ***
// Self-checking bench for the channel, setup and diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module channel_setup_diag_regs_bench;
  logic        core_clk, sys_rst, sclk, cs_n, din, dout, dout_oe_n;
  logic        cal_zero_done, cal_full_done, conv_start, err_summary;
  logic [23:0] cal_result, conv_filter, conv_offset, conv_gain, v, w, starts;
  logic [3:0]  active_channel, ch;
  logic [4:0]  pos_select, neg_select;
  logic [15:0] conv_config;
  int          err_total, tests_run, i;
  logic [7:0]  ra [8] = '{8'h09, 8'h10, 8'h28, 8'h29, 8'h31, 8'h07, 8'h05, 8'h08};
  int          rw [8] = '{16, 16, 24, 24, 24, 24, 8, 8};
  logic [23:0] rv [8] = '{24'h008001, 24'h000001, 24'h060180, 24'h800000, 24'h555555,
                          24'h000040, 24'h00003C, 24'h000000};
  logic [3:0]  seq [4] = '{4'h1, 4'h3, 4'h0, 4'h1};

  channel_setup_diag_regs #(
    .ID_VALUE     (8'h3C),      // Arbitrary identity value
    .GAIN_DEFAULT (24'h555555),
    .CONV_CYCLES  (20),
    .IGNORE_CYC   (600)         // Long enough to cover the first write frame
  ) u_channel_setup_diag_regs (
    .core_clk(core_clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .cal_zero_done(cal_zero_done), .cal_full_done(cal_full_done), .cal_result(cal_result),
    .dout(dout), .dout_oe_n(dout_oe_n), .conv_start(conv_start),
    .active_channel(active_channel), .pos_select(pos_select), .neg_select(neg_select),
    .conv_config(conv_config), .conv_filter(conv_filter), .conv_offset(conv_offset),
    .conv_gain(conv_gain), .err_summary(err_summary)
  );

  host_port_model u_host_port_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  always #5 core_clk = ~core_clk;

  task report_and_stop;
    if (err_total == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  endtask

  task rd(input logic [7:0] a, input int n, output logic [23:0] d);
    u_host_port_model.xfer(8'h40 | a, n, 24'h000000, d);
  endtask

  task wr(input logic [7:0] a, input int n, input logic [23:0] d);
    logic [23:0] unused;
    u_host_port_model.xfer(a, n, d, unused);
  endtask

  task rchk(input logic [7:0] a, input int n, input logic [23:0] exp);
    logic [23:0] d;
    rd(a, n, d);
    chk(d, exp);
  endtask

  // Next conversion start, bounded; returns the channel it started on
  task wait_start(output logic [3:0] c);
    int k;
    for (k = 0; k < 200; k++)
    begin
      @(posedge core_clk);
      #1;
      if (conv_start === 1'b1)
      begin
        c = active_channel;
        return;
      end
    end
    err_total++;
    report_and_stop;
  endtask

  initial
  begin
    core_clk      = 1'b0;
    sys_rst       = 1'b1;
    cal_zero_done = 1'b0;
    cal_full_done = 1'b0;
    cal_result    = 24'h000000;
    err_total     = 0;
    tests_run     = 0;
    repeat (10) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    wr(8'h0A, 16, 24'h009021);
    chk(err_summary, 24'h1);
    rchk(8'h0A, 16, 24'h000001);
    rchk(8'h06, 24, 24'h000040);
    rchk(8'h06, 24, 24'h000000);
    chk(err_summary, 24'h0);
    for (i = 0; i < 8; i++)
      rchk(ra[i], rw[i], rv[i]);
    // Bad address read, read-only write, cut frame
    wr(8'h07, 24, 24'h000078);
    rd(8'h03, 0, v);
    wr(8'h05, 0, 24'h000000);
    rd(8'h09, 4, v);
    rchk(8'h06, 24, 24'h000038);
    // Diagnostics off, master clock count on
    wr(8'h07, 24, 24'h400000);
    rd(8'h03, 0, v);
    rchk(8'h06, 24, 24'h000000);
    // Setup 1: bipolar, reference 2, gain code 5, all buffers on
    wr(8'h1A, 16, 24'h0009F5);
    wr(8'h27, 24, 24'h060123);
    wr(8'h0C, 16, 24'h009343);
    wr(8'h0A, 16, 24'h008043);
    ch = 4'hF;
    for (i = 0; i < 8 && ch !== 4'h0; i++)
      wait_start(ch);
    for (i = 0; i < 4; i++)
    begin
      wait_start(ch);
      chk(ch, seq[i]);
    end
    for (i = 0; i < 8 && ch !== 4'h3; i++)
      wait_start(ch);
    cal_result    = 24'h123456;
    cal_zero_done = 1'b1;
    @(posedge core_clk);
    #1 cal_zero_done = 1'b0;
    cal_full_done = 1'b1;
    cal_result    = 24'hABCDEF;
    @(posedge core_clk);
    #1 cal_full_done = 1'b0;
    chk(conv_config, 24'h0009F5);
    chk(pos_select, 24'h1A);
    chk(neg_select, 24'h03);
    @(posedge core_clk);
    #1;
    chk(conv_offset, 24'h123456);
    chk(conv_gain, 24'hABCDEF);
    chk(conv_filter, 24'h060123);
    rchk(8'h2A, 24, 24'h123456);
    rchk(8'h32, 24, 24'hABCDEF);
    rchk(8'h29, 24, 24'h800000);
    wr(8'h09, 16, 24'h000001);
    wr(8'h0A, 16, 24'h000043);
    wr(8'h0C, 16, 24'h001343);
    repeat (40) @(posedge core_clk);
    #1 ch = active_channel;
    starts = 24'h0;
    repeat (100)
    begin
      @(posedge core_clk);
      #1;
      if (conv_start === 1'b1)
        starts++;
    end
    chk(starts, 24'h0);
    chk(active_channel, ch);
    rd(8'h08, 8, v);
    rd(8'h08, 8, w);
    chk({23'h0, w != v}, 24'h1);
    // A non-continuous mode keeps the sequencer parked even with a channel on
    wr(8'h01, 16, 24'h000004);
    wr(8'h09, 16, 24'h008001);
    starts = 24'h0;
    repeat (100)
    begin
      @(posedge core_clk);
      #1;
      if (conv_start === 1'b1)
        starts++;
    end
    chk(starts, 24'h0);
    wr(8'h01, 16, 24'h000000);
    wait_start(ch);
    chk(ch, 4'h0);
    report_and_stop;
  end
endmodule // channel_setup_diag_regs_bench

bind channel_setup_diag_regs channel_setup_diag_regs_sva #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .cs_n(cs_n), .cal_zero_done(cal_zero_done),
  .cal_full_done(cal_full_done), .cal_result(cal_result), .dout(dout),
  .dout_oe_n(dout_oe_n), .conv_start(conv_start), .active_channel(active_channel),
  .conv_offset(conv_offset), .conv_gain(conv_gain)
);
`default_nettype wire
